// *** rtl/keypad_event_map.vh ***
// Constants for the resistor keypad event queue
// Functional notes
// - Control, identity byte, eight key/duration entries
// - Each sensed resistance maps to unique code
// - Drive enable bit, resets 1, 0 floats
// - Powerdown bit, resets 0, 1 clears queue, floats drive
// - Empty flag read-only, 1 when queue empty
// - Press and release each take one entry
// - Entries reset to key ff, count zero
// - Debounced new state queued, interrupt driven low
// - Duration counts every 32 ms, entry updated
// - Count wraps at 128, overflow bit sticks
// - Any new change restarts count, new entry
// - Full queue overwrites the oldest entry
// - Powerdown or shutdown clears queue to reset
// - Shutdown low floats the drive output
// - Address select pins form address bits 1,0
// - Read while held keeps entry, running duration
// - Held read releases interrupt until next event
// - Read after release pops entry, releases interrupt
// - Only write: address, one control byte, acked
// - Read sends id, control, key, duration
// - Host NACK leaves the read pointer unchanged
// - Upper five address bits fixed 01000
`ifndef KEYPAD_EVENT_MAP_VH
`define KEYPAD_EVENT_MAP_VH

// ****************************************
// Bus address and control layout
// ****************************************
`define ADDR_FIXED 5'h08
`define CTRL_DRIVE_BIT 7
`define CTRL_PDOWN_BIT 6
`define CTRL_EMPTY_BIT 5
`define CTRL_DRIVE_RESET 1'h1
`define CTRL_PDOWN_RESET 1'h0

// ****************************************
// Queue entries
// ****************************************
`define KEY_IDLE 8'hff
`define DUR_RESET 8'h00
`define ENTRY_RESET 16'hff00
`define QUEUE_DEPTH 8

// ****************************************
// Timing
// ****************************************
`define CLK_KHZ 10000
`define DEBOUNCE_MS 18
`define TICK_MS 32

`endif

// *** rtl/event_store.v ***
// Small entry memory with registered read data and bulk clear
`timescale 1ns/1ns
`include "keypad_event_map.vh"

module event_store
#(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Clear to reset contents
    input wire clear,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
integer i;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= `ENTRY_RESET;
        rd_data <= `ENTRY_RESET;
    end
    else
    begin
        if (clear)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= `ENTRY_RESET;
        end
        else if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end
end

endmodule

// *** rtl/resistor_keypad_event_queue.v ***
// Key encoder core: debounce, event queue, duration timer, serial slave
`timescale 1ns/1ns
`include "keypad_event_map.vh"

module resistor_keypad_event_queue
#(
    parameter CNT_W = 20,
    parameter [CNT_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_MS * `CLK_KHZ,
    parameter [CNT_W-1:0] TICK_CYCLES = `TICK_MS * `CLK_KHZ,
    parameter [7:0] IDENTIFICATION_BYTE = 8'h5a // Arbitrary identity value
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Digitised sense measurement
    input wire [7:0] sense_level,
    // Pins
    input wire shutdown_n,
    input wire addr_sel_hi,
    input wire addr_sel_lo,
    // Serial bus
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // Drive output and interrupt
    output wire drive_oe_n,
    output reg key_event_irq_n
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ADDR = 3'h1;
localparam [2:0] S_AACK = 3'h2;
localparam [2:0] S_WR = 3'h3;
localparam [2:0] S_WACK = 3'h4;
localparam [2:0] S_RD = 3'h5;
localparam [2:0] S_RACK = 3'h6;
localparam [2:0] S_WAIT = 3'h7;

// Every distinct measurement is its own code, so codes stay unique
function [7:0] decode_key;
    input [7:0] level;
    begin
        decode_key = level;
    end
endfunction

function [7:0] byte_of;
    input [1:0] idx;
    input [7:0] ctrl;
    input [15:0] ent;
    begin
        case (idx)
            2'h0: byte_of = IDENTIFICATION_BYTE;
            2'h1: byte_of = ctrl;
            2'h2: byte_of = ent[15:8];
            default: byte_of = ent[7:0];
        endcase
    end
endfunction

// ****************************************
// Input synchronisers
// ****************************************
reg scl_s1, scl_s2, scl_d;
reg sda_s1, sda_s2, sda_d;
reg shutdown_n_s1, shutdown_n_s2;
reg ahi_s1, ahi_s2, alo_s1, alo_s2;
reg [7:0] sense_s1, sense_s2;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        scl_s1 <= 1'h1;
        scl_s2 <= 1'h1;
        scl_d <= 1'h1;
        sda_s1 <= 1'h1;
        sda_s2 <= 1'h1;
        sda_d <= 1'h1;
        shutdown_n_s1 <= 1'h0;
        shutdown_n_s2 <= 1'h0;
        ahi_s1 <= 1'h0;
        ahi_s2 <= 1'h0;
        alo_s1 <= 1'h0;
        alo_s2 <= 1'h0;
        sense_s1 <= `KEY_IDLE;
        sense_s2 <= `KEY_IDLE;
    end
    else
    begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        scl_d <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_d <= sda_s2;
        shutdown_n_s1 <= shutdown_n;
        shutdown_n_s2 <= shutdown_n_s1;
        ahi_s1 <= addr_sel_hi;
        ahi_s2 <= ahi_s1;
        alo_s1 <= addr_sel_lo;
        alo_s2 <= alo_s1;
        sense_s1 <= sense_level;
        sense_s2 <= sense_s1;
    end
end

wire scl_rise = scl_s2 & ~scl_d;
wire scl_fall = ~scl_s2 & scl_d;
wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

// ****************************************
// Control bits and clear
// ****************************************
reg drive_ctl, pdown_ctl;
reg [3:0] count;
wire queue_empty = (count == 4'h0);
wire clr = ~shutdown_n_s2 | pdown_ctl;
wire [7:0] ctrl_rd = {drive_ctl, pdown_ctl, queue_empty, 5'h00};

// Floats while disabled by software or held in shutdown
assign drive_oe_n = ~(drive_ctl & shutdown_n_s2 & ~pdown_ctl);

// ****************************************
// Debounce
// ****************************************
reg [7:0] cand, accepted;
reg [CNT_W-1:0] stab;
reg new_event;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cand <= `KEY_IDLE;
        accepted <= `KEY_IDLE;
        stab <= {CNT_W{1'b0}};
        new_event <= 1'h0;
    end
    else if (clr)
    begin
        cand <= `KEY_IDLE;
        accepted <= `KEY_IDLE;
        stab <= {CNT_W{1'b0}};
        new_event <= 1'h0;
    end
    else
    begin
        new_event <= 1'h0;
        if (decode_key(sense_s2) != cand)
        begin
            cand <= decode_key(sense_s2);
            stab <= {CNT_W{1'b0}};
        end
        else if (stab != DEBOUNCE_CYCLES - 1'b1)
            stab <= stab + 1'b1;
        else if (cand != accepted)
        begin
            accepted <= cand;
            new_event <= 1'h1;
        end
    end
end

// ****************************************
// Queue and duration timer
// ****************************************
reg [2:0] head, cur_idx;
reg cur_valid;
reg [7:0] dur;
reg [CNT_W-1:0] tick_cnt;
reg rd_done;
wire [15:0] rd_data;

wire full = count[3];
wire [2:0] tail = head + count[2:0];
wire tick_hit = cur_valid & (tick_cnt == TICK_CYCLES - 1'b1);
wire [7:0] next_dur = {dur[7] | (&dur[6:0]), dur[6:0] + 7'h01};
// Held key on the oldest entry: the host sees it but it stays
wire live = cur_valid & (head == cur_idx) & (accepted != `KEY_IDLE);
wire ev_full = new_event & full;
// An overwrite already drops the oldest entry, so a pop then would lose one
wire pop = rd_done & ~live & ~queue_empty & ~ev_full;
wire mem_we = new_event | tick_hit;
wire [2:0] mem_wa = new_event ? tail : cur_idx;
wire [15:0] mem_wd = new_event ? {accepted, `DUR_RESET} : {accepted, next_dur};

event_store #(.WIDTH(16), .DEPTH(`QUEUE_DEPTH), .AW(3)) store
(
    .clk(clk),
    .rst_n(rst_n),
    .clear(clr),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(head),
    .rd_data(rd_data)
);

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        head <= 3'h0;
        count <= 4'h0;
        cur_idx <= 3'h0;
        cur_valid <= 1'h0;
        dur <= `DUR_RESET;
        tick_cnt <= {CNT_W{1'b0}};
        key_event_irq_n <= 1'h1;
    end
    else if (clr)
    begin
        head <= 3'h0;
        count <= 4'h0;
        cur_valid <= 1'h0;
        dur <= `DUR_RESET;
        tick_cnt <= {CNT_W{1'b0}};
        key_event_irq_n <= 1'h1;
    end
    else
    begin
        head <= head + {2'h0, ev_full} + {2'h0, pop};
        count <= count + {3'h0, new_event & ~full} - {3'h0, pop};
        if (new_event)
        begin
            cur_idx <= tail;
            cur_valid <= 1'h1;
            dur <= `DUR_RESET;
            tick_cnt <= {CNT_W{1'b0}};
        end
        else
        begin
            if (pop & (head == cur_idx))
                cur_valid <= 1'h0;
            if (tick_hit)
            begin
                tick_cnt <= {CNT_W{1'b0}};
                dur <= next_dur;
            end
            else if (cur_valid)
                tick_cnt <= tick_cnt + 1'b1;
        end
        // A new event in the cycle of a read keeps the line low
        if (new_event)
            key_event_irq_n <= 1'h0;
        else if (rd_done)
            key_event_irq_n <= 1'h1;
    end
end

// ****************************************
// Serial slave
// ****************************************
reg [2:0] st;
reg [3:0] bitcnt;
reg [7:0] shreg;
reg [1:0] byte_idx;
reg [15:0] ent;
reg rw, mack, sda_low;
wire [6:0] my_addr = {`ADDR_FIXED, ahi_s2, alo_s2};
wire [1:0] nidx = byte_idx + 2'h1;
wire [7:0] nbyte = byte_of(nidx, ctrl_rd, (nidx == 2'h2) ? rd_data : ent);

// Open drain: only ever pulls low
assign sda_out = 1'h0;
assign sda_oe_n = ~sda_low;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st <= S_IDLE;
        bitcnt <= 4'h0;
        shreg <= 8'h00;
        byte_idx <= 2'h0;
        ent <= `ENTRY_RESET;
        rw <= 1'h0;
        mack <= 1'h0;
        sda_low <= 1'h0;
        rd_done <= 1'h0;
        drive_ctl <= `CTRL_DRIVE_RESET;
        pdown_ctl <= `CTRL_PDOWN_RESET;
    end
    else
    begin
        rd_done <= 1'h0;
        if (bus_start)
        begin
            st <= S_ADDR;
            bitcnt <= 4'h0;
            sda_low <= 1'h0;
        end
        else if (bus_stop)
        begin
            st <= S_IDLE;
            sda_low <= 1'h0;
        end
        else if (scl_rise)
        begin
            if (st == S_ADDR || st == S_WR)
            begin
                shreg <= {shreg[6:0], sda_s2};
                bitcnt <= bitcnt + 4'h1;
            end
            else if (st == S_RACK)
                mack <= ~sda_s2;
        end
        else if (scl_fall)
        begin
            case (st)
                S_ADDR:
                    if (bitcnt == 4'h8)
                    begin
                        if (shreg[7:1] == my_addr)
                        begin
                            sda_low <= 1'h1;
                            rw <= shreg[0];
                            st <= S_AACK;
                        end
                        else
                            st <= S_WAIT;
                    end
                S_AACK:
                begin
                    bitcnt <= 4'h0;
                    if (rw)
                    begin
                        byte_idx <= 2'h0;
                        shreg <= IDENTIFICATION_BYTE;
                        sda_low <= ~IDENTIFICATION_BYTE[7];
                        st <= S_RD;
                    end
                    else
                    begin
                        sda_low <= 1'h0;
                        st <= S_WR;
                    end
                end
                S_WR:
                    if (bitcnt == 4'h8)
                    begin
                        sda_low <= 1'h1;
                        drive_ctl <= shreg[`CTRL_DRIVE_BIT];
                        pdown_ctl <= shreg[`CTRL_PDOWN_BIT];
                        st <= S_WACK;
                    end
                S_WACK:
                begin
                    // Later bytes are not acknowledged
                    sda_low <= 1'h0;
                    st <= S_WAIT;
                end
                S_RD:
                begin
                    bitcnt <= bitcnt + 4'h1;
                    if (bitcnt == 4'h7)
                    begin
                        sda_low <= 1'h0;
                        st <= S_RACK;
                    end
                    else
                    begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_low <= ~shreg[6];
                    end
                end
                S_RACK:
                    if (!mack)
                        st <= S_WAIT;
                    else if (byte_idx == 2'h3)
                    begin
                        rd_done <= 1'h1;
                        st <= S_WAIT;
                    end
                    else
                    begin
                        byte_idx <= nidx;
                        if (nidx == 2'h2)
                            ent <= rd_data;
                        shreg <= nbyte;
                        sda_low <= ~nbyte[7];
                        bitcnt <= 4'h0;
                        st <= S_RD;
                    end
                default:
                    st <= st;
            endcase
        end
    end
end

endmodule

// *** verification/keypad_asserts.sv ***
// Port-level concurrent checks for the keypad event queue
`timescale 1ns/1ns
module keypad_asserts
#(
    parameter DEBOUNCE_CYCLES = 20
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Inputs
    input wire [7:0] sense_level,
    input wire shutdown_n,
    input wire addr_sel_hi,
    input wire addr_sel_lo,
    input wire scl_in,
    input wire sda_in,
    // Outputs
    input wire sda_out,
    input wire sda_oe_n,
    input wire drive_oe_n,
    input wire key_event_irq_n
);
    reg [19:0] stable_cnt;
    reg [7:0] sense_q;
    reg [7:0] quiet;
    reg scl_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ********
    // Helper counters
    // ********
    // Both saturate so long idle spans never wrap into a false match
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stable_cnt <= 20'h00000;
            sense_q <= 8'hff;
            quiet <= 8'h00;
            scl_q <= 1'h1;
        end
        else
        begin
            sense_q <= sense_level;
            scl_q <= scl_in;
            if (sense_level != sense_q)
                stable_cnt <= 20'h00000;
            else if (~&stable_cnt)
                stable_cnt <= stable_cnt + 20'h00001;
            if (scl_in != scl_q)
                quiet <= 8'h00;
            else if (~&quiet)
                quiet <= quiet + 8'h01;
        end
    end
    // ********
    // Properties
    // ********
    property p_shut_float;
        !shutdown_n [*4] |-> drive_oe_n;
    endproperty
    a_shut_float: assert property (p_shut_float)
        else $error("drive output active in shutdown");
    property p_shut_irq;
        !shutdown_n [*4] |-> key_event_irq_n;
    endproperty
    a_shut_irq: assert property (p_shut_irq)
        else $error("interrupt low in shutdown");
    property p_wake_drive;
        $fell(drive_oe_n) |-> $past(shutdown_n, 2);
    endproperty
    a_wake_drive: assert property (p_wake_drive)
        else $error("drive enabled while shut down");
    property p_irq_debounce;
        $fell(key_event_irq_n) |-> stable_cnt >= DEBOUNCE_CYCLES;
    endproperty
    a_irq_debounce: assert property (p_irq_debounce)
        else $error("event before sense level settled");
    property p_irq_release;
        $rose(key_event_irq_n) |-> quiet < 8'd20 || !$past(shutdown_n, 3);
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("interrupt released without bus read");
    property p_scl_hold;
        $rose(scl_in) |=> $stable(sda_oe_n) [*3];
    endproperty
    a_scl_hold: assert property (p_scl_hold)
        else $error("data line moved while clock high");
    property p_idle_release;
        quiet > 8'd40 |-> sda_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data line held on idle bus");
    property p_oe_bound;
        $fell(sda_oe_n) |-> ##[1:100] sda_oe_n;
    endproperty
    a_oe_bound: assert property (p_oe_bound)
        else $error("data line not released for ninth bit");
endmodule
bind resistor_keypad_event_queue keypad_asserts
    #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_keypad_asserts (
    .clk(clk), .rst_n(rst_n), .sense_level(sense_level),
    .shutdown_n(shutdown_n), .addr_sel_hi(addr_sel_hi),
    .addr_sel_lo(addr_sel_lo), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .drive_oe_n(drive_oe_n),
    .key_event_irq_n(key_event_irq_n));

// *** verification/i2c_host.sv ***
// Bus master model standing in for the host processor
`timescale 1ns/1ns
module i2c_host
(
    // Clock
    input wire clk,
    // Device side of the data line
    input wire dev_out,
    input wire dev_oe_n,
    // Bus lines
    output reg scl,
    output wire sda
);
    reg m_sda;
    reg junk;
    reg [7:0] jb;
    // Pulled-up line: low when either party pulls it
    assign sda = m_sda & (dev_oe_n | dev_out);
    initial
    begin
        scl = 1'h1;
        m_sda = 1'h1;
    end
    task hp;
        repeat (4) @(negedge clk);
    endtask
    // Data moves one cycle after the clock falls, never while it is high
    // Four cycles low and four high make the 800 ns bit period
    task bit_io(input b, output r);
    begin
        @(negedge clk);
        m_sda = b;
        repeat (3) @(negedge clk);
        scl = 1'h1;
        hp;
        r = sda;
        scl = 1'h0;
    end
    endtask
    task byte_io(input [7:0] tx, input a_in, output [7:0] rx, output a_out);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(tx[i], rx[i]);
        bit_io(a_in, a_out);
    end
    endtask
    task start;
    begin
        m_sda = 1'h1;
        scl = 1'h1;
        hp;
        m_sda = 1'h0;
        hp;
        scl = 1'h0;
    end
    endtask
    task stop;
    begin
        @(negedge clk);
        m_sda = 1'h0;
        hp;
        scl = 1'h1;
        hp;
        m_sda = 1'h1;
        hp;
    end
    endtask
    // Address with write bit, one control byte, then STOP
    task wr(input [6:0] a, input [7:0] d, output [1:0] acks);
    begin
        start;
        byte_io({a, 1'h0}, 1'h1, jb, acks[1]);
        byte_io(d, 1'h1, jb, acks[0]);
        stop;
    end
    endtask
    // Four bytes read; a NACK on the last one leaves the entry in place
    task rd(input [6:0] a, input nack, output [31:0] f, output ack);
        integer i;
    begin
        start;
        byte_io({a, 1'h1}, 1'h1, jb, ack);
        for (i = 0; i < 4; i = i + 1)
        begin
            byte_io(8'hff, (i == 3) & nack, jb, junk);
            f = {f[23:0], jb};
        end
        stop;
    end
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the keypad event queue
`timescale 1ns/1ns
module tb_top;
    localparam DEB = 20;
    localparam TICK = 50;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    reg [7:0] sense_level = 8'hff;
    reg shutdown_n = 1'h1;
    reg addr_sel_hi = 1'h0;
    reg addr_sel_lo = 1'h1;
    wire scl, sda, sda_out, sda_oe_n, drive_oe_n, key_event_irq_n;
    integer n_errors = 0;
    integer checks_done = 0;
    integer k;
    reg [31:0] f;
    reg [31:0] g;
    reg [1:0] acks;
    reg ack;
    always #50 clk = ~clk;
    resistor_keypad_event_queue #(.DEBOUNCE_CYCLES(20'd20),
        .TICK_CYCLES(20'd50)) u_resistor_keypad_event_queue (
        .clk(clk), .rst_n(rst_n), .sense_level(sense_level),
        .shutdown_n(shutdown_n), .addr_sel_hi(addr_sel_hi),
        .addr_sel_lo(addr_sel_lo), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .drive_oe_n(drive_oe_n),
        .key_event_irq_n(key_event_irq_n));
    i2c_host u_i2c_host (.clk(clk), .dev_out(sda_out),
        .dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));
    // ********
    // Tasks
    // ********
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task press(input [7:0] v);
    begin
        sense_level = v;
        cyc(DEB + 10);
    end
    endtask
    task rd(input nack);
    begin
        u_i2c_host.rd({5'h08, addr_sel_hi, addr_sel_lo}, nack, f, ack);
        chk(ack, 0);
    end
    endtask
    task wr(input [7:0] d);
    begin
        u_i2c_host.wr({5'h08, addr_sel_hi, addr_sel_lo}, d, acks);
        chk(acks, 0);
    end
    endtask
    task done(input [8*10-1:0] s);
        $display("test %0s done", s);
    endtask
    task give_verdict;
    begin
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // ********
    // Tests
    // ********
    initial
    begin
        cyc(10);
        rst_n = 1'h1;
        cyc(10);
        chk(key_event_irq_n, 1);
        rd(0);
        chk(f, 32'h5aa0ff00);
        done("reset");
        addr_sel_hi = 1'h1;
        addr_sel_lo = 1'h0;
        cyc(4);
        u_i2c_host.rd(7'h20, 1'h0, f, ack);
        chk({ack, f[31:1]}, 32'hffffffff);
        rd(0);
        chk(f[31:8], 24'h5aa0ff);
        done("address");
        wr(8'h1f);
        chk(drive_oe_n, 1);
        rd(0);
        chk(f[23:16], 8'h20);
        wr(8'h80);
        chk(drive_oe_n, 0);
        done("control");
        sense_level = 8'h33;
        cyc(DEB / 2);
        press(8'hff);
        chk(key_event_irq_n, 1);
        done("glitch");
        press(8'h42);
        chk(key_event_irq_n, 0);
        rd(0);
        chk(f[23:8], 16'h8042);
        g = f;
        chk(key_event_irq_n, 1);
        cyc(TICK * 3);
        rd(0);
        chk(f[15:8], 8'h42);
        chk(f[6:0] > g[6:0], 1);
        chk(key_event_irq_n, 1);
        done("held");
        press(8'hff);
        chk(key_event_irq_n, 0);
        rd(1);
        chk(key_event_irq_n, 0);
        g = f;
        rd(0);
        chk(f, g);
        chk(f[15:8], 8'h42);
        rd(0);
        chk(f[23:8], 16'h80ff);
        chk(key_event_irq_n, 1);
        rd(0);
        chk(f[23:16], 8'ha0);
        done("release");
        sense_level = 8'h11;
        cyc(TICK * 129 + DEB);
        rd(0);
        chk(f[15:7], 9'h023);
        press(8'hff);
        rd(0);
        chk(f[15:7], 9'h023);
        done("overflow");
        press(8'h55);
        chk(key_event_irq_n, 0);
        sense_level = 8'hff;
        shutdown_n = 1'h0;
        cyc(10);
        chk(drive_oe_n, 1);
        chk(key_event_irq_n, 1);
        shutdown_n = 1'h1;
        cyc(10);
        chk(drive_oe_n, 0);
        rd(0);
        chk(f[23:0], 24'ha0ff00);
        done("shutdown");
        for (k = 1; k < 10; k = k + 1)
            press(k[7:0]);
        rd(0);
        chk(f[15:8], 8'h02);
        rd(0);
        chk(f[15:8], 8'h03);
        done("overwrite");
        wr(8'hc0);
        rd(0);
        chk(f[23:0], 24'he0ff00);
        wr(8'h80);
        done("powerdown");
        give_verdict;
    end
    // Whole run needs under 20000 cycles
    initial
    begin
        #3000000;
        n_errors = n_errors + 1;
        give_verdict;
    end
endmodule
